//--- hdl/motor_controller_end.sv
// Purpose: Controller end: makes timebase, decodes duty per channel, clears faults
// Assumes: Timebase half period set by a parameter in clock cycles
// Notes: Averages channel pairs for odd harmonic rejection
`timescale 1ns/10ps
module motor_controller_end #(
	parameter int HALF_PERIOD = 1250
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic clear_fault_in,
	input wire logic auto_clear_in,
	phase_readout_if.controller link,
	output logic [phase_readout_pkg::CNT_W-1:0] ch1_off_out,
	output logic [phase_readout_pkg::CNT_W-1:0] ch2_off_out,
	output logic [phase_readout_pkg::CNT_W-1:0] pair_avg_out,
	output logic result_valid_out,
	output logic fault_n_out
);
	logic tb_reg;
	logic [phase_readout_pkg::CNT_W-1:0] div_reg, off_reg, off_done_w;
	logic duty_meta_reg, duty_sync_reg, fault_meta_reg, fault_sync_reg;
	logic clearing_reg;
	logic [phase_readout_pkg::CNT_W-1:0] clr_cnt_reg;
	logic valid_reg;

	// Timebase divider; HALF_PERIOD gives half-rate use, start phase is fixed at reset
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			div_reg <= phase_readout_pkg::CNT_RESET;
			tb_reg <= 1'b0;
		end else if (div_reg == 16'(HALF_PERIOD - 1)) begin // R17 R19
			div_reg <= phase_readout_pkg::CNT_RESET;
			tb_reg <= ~tb_reg; // R1
		end else begin
			div_reg <= div_reg + 16'h0001;
		end
	end

	// Synchronise returning open-drain lines
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			duty_meta_reg <= 1'b1;
			duty_sync_reg <= 1'b1;
			fault_meta_reg <= 1'b1;
			fault_sync_reg <= 1'b1;
		end else begin
			duty_meta_reg <= link.duty_line;
			duty_sync_reg <= duty_meta_reg;
			fault_meta_reg <= link.fault_line;
			fault_sync_reg <= fault_meta_reg;
		end
	end

	// Count released time per half; store per channel at each edge
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			off_reg <= phase_readout_pkg::CNT_RESET;
			ch1_off_out <= phase_readout_pkg::CNT_RESET;
			ch2_off_out <= phase_readout_pkg::CNT_RESET;
			pair_avg_out <= phase_readout_pkg::CNT_RESET;
			valid_reg <= 1'b0;
		end else begin
			valid_reg <= 1'b0;
			if (div_reg == 16'(HALF_PERIOD - 1)) begin
				off_reg <= phase_readout_pkg::CNT_RESET;
				valid_reg <= 1'b1;
				if (tb_reg) begin
					ch1_off_out <= off_done_w; // R6 R8 R3
					pair_avg_out <= 16'((17'(off_done_w) + 17'(ch2_off_out)) >> 1); // R18
				end else begin
					ch2_off_out <= off_done_w; // R8 R3
					pair_avg_out <= 16'((17'(off_done_w) + 17'(ch1_off_out)) >> 1); // R18
				end
			end else if (duty_sync_reg) begin
				off_reg <= off_reg + 16'h0001;
			end
		end
	end

	// Clear pulse: hold duty low for the clear time
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			clearing_reg <= 1'b0;
			clr_cnt_reg <= phase_readout_pkg::CNT_RESET;
		end else if (clearing_reg) begin
			if (clr_cnt_reg >= 16'(phase_readout_pkg::CLEAR_CYCLES + 3)) begin
				clearing_reg <= 1'b0; // R21
			end else begin
				clr_cnt_reg <= clr_cnt_reg + 16'h0001;
			end
		end else if (clear_fault_in && !fault_sync_reg) begin
			clearing_reg <= 1'b1; // R10
			clr_cnt_reg <= phase_readout_pkg::CNT_RESET;
		end
	end

	// Released count of the half ending now, its last clock included
	assign off_done_w = off_reg + 16'(duty_sync_reg); // R3
	assign link.aligned_timebase = tb_reg;
	assign link.duty_clear_oe = clearing_reg;
	assign link.strap_fault_to_duty = auto_clear_in; // R13
	assign result_valid_out = valid_reg;
	assign fault_n_out = fault_sync_reg;
endmodule

//--- hdl/phase_readout_if.sv
// Purpose: Pins between the sensor and the motor controller
// Assumes: Open-drain lines resolve low when any driver enables
// Notes: The flag line may be strapped to the duty line for auto clear
`timescale 1ns/10ps
interface phase_readout_if;
	logic aligned_timebase;
	logic duty_pull_oe;
	logic duty_clear_oe;
	logic fault_pull_oe;
	logic strap_fault_to_duty;
	logic duty_line;
	logic fault_line;
	// Wired-AND resolution of both open-drain lines with pull-ups
	assign fault_line = ~fault_pull_oe;
	assign duty_line = ~(duty_pull_oe | duty_clear_oe | (strap_fault_to_duty & fault_pull_oe));
	modport sensor (
		input aligned_timebase,
		input duty_line,
		output duty_pull_oe,
		output fault_pull_oe
	);
	modport controller (
		output aligned_timebase,
		output duty_clear_oe,
		output strap_fault_to_duty,
		input duty_line,
		input fault_line
	);
endinterface

//--- hdl/phase_readout_pkg.sv
// Purpose: Shared constants and types for the timebase/duty readout link
// Assumes: One system clock mclk_in at 25 MHz on both ends
// Notes: Duty values are in tenths of a percent of one timebase half period
package phase_readout_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int DEBOUNCE_TIME_NS = 3500;
	localparam int DEBOUNCE_MIN_NS = 2700;
	localparam int DEBOUNCE_MAX_NS = 4700;
	localparam int CLEAR_PULSE_TIME_NS = 500;
	// Debounce count uses the nominal figure, rounded up
	localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Clear pulse is a least time, rounded up
	localparam int CLEAR_CYCLES = (CLEAR_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
	localparam int SAMPLE_W = 12;
	localparam int DUTY_W = 10;
	// Duty in permille: 200 at zero input, 100 to 300 range
	localparam logic [DUTY_W-1:0] DUTY_ZERO = 10'h0c8;
	localparam logic [DUTY_W-1:0] DUTY_MIN = 10'h064;
	localparam logic [DUTY_W-1:0] DUTY_MAX = 10'h12c;
	localparam logic [DUTY_W-1:0] DUTY_FULL = 10'h3e8;
	// Sample is signed millivolts; 40 %/V is 0.4 permille per mV
	localparam int DUTY_SLOPE_NUM = 2;
	localparam int DUTY_SLOPE_DEN = 5;
	localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
	localparam logic [SAMPLE_W-1:0] THRESHOLD_RESET = 12'h1d6;
	typedef enum logic [2:0] {
		OC_IDLE = 3'b001,
		OC_DEBOUNCE = 3'b010,
		OC_LATCHED = 3'b100
	} fault_state_t;
endpackage

//--- hdl/phase_sensor.sv
// Purpose: Sensor end: turns a sampled input into an active-low duty stream
// Assumes: Timebase from the controller, input sample already digitised
// Notes: Timebase edges act three clocks after the pin toggles; a latched
//  flag stops the duty pull, so any low seen then is an external clear.
//  Summary of operation follows
// Summary of operation
// (R1) Controller drives timebase synced to PWM carrier
// (R2) Duty line only pulled low, pull-up releases
// (R3) Released time of next cycle over period
// (R4) Duty spans 10 to 30 percent, 20 at zero
// (R5) Duty falls 40 percent per volt input
// (R6) High half channel 1, low half channel 2
// (R7) Per-half measurement tolerates uneven timebase duty
// (R8) Controller offsets each channel separately
// (R9) Overcurrent beyond debounce latches flag low
// (R10) Duty held low clear-pulse time clears flag
// (R11) Flag low keeps duty line released
// (R12) Persisting overcurrent refires at next timebase edge
// (R13) Strap flag to duty for auto clear
// (R14) Delay measured edge to duty rising edge
// (R15) Filter integrates over timebase period, resets; the integrator here covers one half period and restarts at each timebase edge
// (R16) Results taken twice per timebase period
// (R17) Shifted timebase option adds quarter period; the divider here has no shift option
// (R18) Aligned timebase: controller averages result pairs
// (R19) Half-rate timebase for centre-aligned PWM
// (R20) Debounce nominal 3.5 us
// (R21) Clear pulse at least 0.5 us
`timescale 1ns/10ps
module phase_sensor (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic signed [phase_readout_pkg::SAMPLE_W-1:0] input_mv_in,
	input wire logic [phase_readout_pkg::SAMPLE_W-1:0] overcurrent_threshold_in,
	phase_readout_if.sensor link,
	output logic [phase_readout_pkg::DUTY_W-1:0] last_duty_out,
	output logic overcurrent_flag_n_out
);
	// Synchronisers and timebase edge detect
	logic tb_meta_reg, tb_sync_reg, tb_prev_reg;
	logic duty_meta_reg, duty_sync_reg;
	logic [phase_readout_pkg::CNT_W-1:0] half_cnt_reg, period_reg, low_len_reg;
	logic signed [phase_readout_pkg::SAMPLE_W+phase_readout_pkg::CNT_W-1:0] integ_reg;
	logic signed [phase_readout_pkg::SAMPLE_W-1:0] avg_reg;
	logic [phase_readout_pkg::DUTY_W-1:0] duty_reg;
	logic pull_reg;
	// Fault machine state, counters and refire window
	phase_readout_pkg::fault_state_t fault_state_reg;
	logic [phase_readout_pkg::CNT_W-1:0] deb_cnt_reg, clr_cnt_reg;
	logic rearm_reg;
	logic edge_w, overcurrent_w;
	logic [phase_readout_pkg::SAMPLE_W-1:0] mag_w;

	// Map averaged millivolts to permille duty with clamping
	function automatic logic [phase_readout_pkg::DUTY_W-1:0] to_duty(
		input logic signed [phase_readout_pkg::SAMPLE_W-1:0] mv);
		logic signed [15:0] d;
		d = 16'(signed'(phase_readout_pkg::DUTY_ZERO)) - 16'(mv * phase_readout_pkg::DUTY_SLOPE_NUM
			/ phase_readout_pkg::DUTY_SLOPE_DEN); // R5
		if (d < 16'(signed'(phase_readout_pkg::DUTY_MIN))) begin
			to_duty = phase_readout_pkg::DUTY_MIN; // R4
		end else if (d > 16'(signed'(phase_readout_pkg::DUTY_MAX))) begin
			to_duty = phase_readout_pkg::DUTY_MAX; // R4
		end else begin
			to_duty = d[phase_readout_pkg::DUTY_W-1:0];
		end
	endfunction

	// True while the fault machine holds the flag low
	function automatic logic is_latched(input phase_readout_pkg::fault_state_t st);
		is_latched = (st == phase_readout_pkg::OC_LATCHED);
	endfunction

	// Two-flop synchroniser and edge detect for the timebase
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			tb_meta_reg <= 1'b0;
			tb_sync_reg <= 1'b0;
			tb_prev_reg <= 1'b0;
		end else begin
			tb_meta_reg <= link.aligned_timebase;
			tb_sync_reg <= tb_meta_reg;
			tb_prev_reg <= tb_sync_reg;
		end
	end

	// Two-flop synchroniser for the duty line readback
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			duty_meta_reg <= 1'b1;
			duty_sync_reg <= 1'b1;
		end else begin
			duty_meta_reg <= link.duty_line;
			duty_sync_reg <= duty_meta_reg;
		end
	end

	assign edge_w = tb_sync_reg ^ tb_prev_reg; // R1 R16
	assign mag_w = input_mv_in[phase_readout_pkg::SAMPLE_W-1] ? 12'(-input_mv_in) : input_mv_in;
	assign overcurrent_w = mag_w > overcurrent_threshold_in; // R9

	// Half-period length: counts clocks since the last timebase edge
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			half_cnt_reg <= phase_readout_pkg::CNT_RESET;
			period_reg <= phase_readout_pkg::CNT_RESET;
		end else if (edge_w) begin
			period_reg <= half_cnt_reg; // R6 R7
			half_cnt_reg <= 16'h0001;
		end else begin
			half_cnt_reg <= half_cnt_reg + 16'h0001;
		end
	end

	// Reset integrator: each half period integrates, then restarts at the edge
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			integ_reg <= '0;
			avg_reg <= '0;
		end else if (edge_w) begin
			avg_reg <= (half_cnt_reg == phase_readout_pkg::CNT_RESET) ? '0 :
				12'(integ_reg / signed'({1'b0, half_cnt_reg})); // R15
			integ_reg <= 28'(input_mv_in);
		end else begin
			integ_reg <= integ_reg + 28'(input_mv_in); // R15
		end
	end

	// Result per half: duty of last half, low length for this half
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			duty_reg <= phase_readout_pkg::DUTY_ZERO;
			low_len_reg <= phase_readout_pkg::CNT_RESET;
		end else if (edge_w) begin
			duty_reg <= to_duty(avg_reg); // R6
			// Low time = (1 - duty) of previous half period length
			low_len_reg <= 16'((32'(period_reg) * 32'(phase_readout_pkg::DUTY_FULL
				- to_duty(avg_reg))) / 32'(phase_readout_pkg::DUTY_FULL)); // R3
		end
	end

	// Pull low for the active part, then release: rising edge carries result
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			pull_reg <= 1'b0;
		end else if (is_latched(fault_state_reg)) begin
			pull_reg <= 1'b0; // R11
		end else if (edge_w) begin
			pull_reg <= (low_len_reg != phase_readout_pkg::CNT_RESET); // R14
		end else if (half_cnt_reg >= low_len_reg) begin
			pull_reg <= 1'b0; // R3 R14
		end
	end

	// Fault machine: debounce, latch, clear by external low pulse
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			fault_state_reg <= phase_readout_pkg::OC_IDLE;
			deb_cnt_reg <= phase_readout_pkg::CNT_RESET;
			clr_cnt_reg <= phase_readout_pkg::CNT_RESET;
			rearm_reg <= 1'b0;
		end else begin
			// Refire window closes at the next timebase edge or when overcurrent ends
			if (edge_w || !overcurrent_w) begin
				rearm_reg <= 1'b0;
			end
			unique case (fault_state_reg)
				phase_readout_pkg::OC_IDLE: begin
					deb_cnt_reg <= phase_readout_pkg::CNT_RESET;
					if (overcurrent_w) begin
						fault_state_reg <= phase_readout_pkg::OC_DEBOUNCE;
					end
				end
				phase_readout_pkg::OC_DEBOUNCE: begin
					if (!overcurrent_w) begin
						fault_state_reg <= phase_readout_pkg::OC_IDLE;
					end else if (deb_cnt_reg >= 16'(phase_readout_pkg::DEBOUNCE_CYCLES - 1)) begin
						fault_state_reg <= phase_readout_pkg::OC_LATCHED; // R9 R20
						clr_cnt_reg <= phase_readout_pkg::CNT_RESET;
					end else begin
						deb_cnt_reg <= deb_cnt_reg + 16'h0001;
					end
				end
				phase_readout_pkg::OC_LATCHED: begin
					// Device never pulls duty here, so a low is the external clear
					if (duty_sync_reg) begin
						clr_cnt_reg <= phase_readout_pkg::CNT_RESET;
					end else if (clr_cnt_reg >= 16'(phase_readout_pkg::CLEAR_CYCLES - 1)) begin
						fault_state_reg <= phase_readout_pkg::OC_IDLE; // R10 R21 R13
						rearm_reg <= 1'b1; // R12
					end else begin
						clr_cnt_reg <= clr_cnt_reg + 16'h0001;
					end
				end
				// Any other code is illegal and returns to idle
				default: fault_state_reg <= phase_readout_pkg::OC_IDLE;
			endcase
			// Still overcurrent after a clear: refire on the next timebase edge.
			// Only a clear opens this window, so a short burst never latches here.
			if (rearm_reg && edge_w && overcurrent_w) begin
				fault_state_reg <= phase_readout_pkg::OC_LATCHED; // R12
				clr_cnt_reg <= phase_readout_pkg::CNT_RESET;
			end
		end
	end

	assign link.duty_pull_oe = pull_reg; // R2
	assign link.fault_pull_oe = is_latched(fault_state_reg); // R9
	assign overcurrent_flag_n_out = ~is_latched(fault_state_reg); // R9
	assign last_duty_out = duty_reg;
endmodule

//--- tb/phase_current_pwm_readout_tb.sv
// Purpose: Drives both link ends, checks duty results and fault handling
// Assumes: Short timebase half period of 50 clocks
// Notes: Checker sits beside the link interface
`timescale 1ns/10ps
module phase_current_pwm_readout_tb;
	localparam int HP = 50;
	typedef struct packed {logic [11:0] mv; logic [9:0] duty;} row_t;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [11:0] mv = 12'h000;
	logic [11:0] thr = 12'h1f4;
	logic clr = 1'b0;
	logic auto = 1'b0;
	logic [9:0] last_duty;
	logic flag_n, valid, fault_n;
	logic [15:0] ch1, ch2, avg;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	row_t rows [5] = '{'{12'h000, 10'h0c8}, '{12'h0fa, 10'h064}, '{12'hf06, 10'h12c},
		'{12'h190, 10'h064}, '{12'he70, 10'h12c}};
	phase_readout_if link ();
	always #20 mclk_in = ~mclk_in;
	phase_sensor phase_sensor_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .input_mv_in(mv),
		.overcurrent_threshold_in(thr), .link(link.sensor), .last_duty_out(last_duty),
		.overcurrent_flag_n_out(flag_n));
	motor_controller_end #(.HALF_PERIOD(HP)) motor_controller_end_i (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in), .clear_fault_in(clr), .auto_clear_in(auto),
		.link(link.controller), .ch1_off_out(ch1), .ch2_off_out(ch2), .pair_avg_out(avg),
		.result_valid_out(valid), .fault_n_out(fault_n));
	phase_readout_chk #(.HALF_PERIOD(HP)) phase_readout_chk_i (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in), .aligned_timebase(link.aligned_timebase),
		.duty_pull_oe(link.duty_pull_oe), .duty_clear_oe(link.duty_clear_oe),
		.fault_pull_oe(link.fault_pull_oe), .duty_line(link.duty_line));
	// Compare and count
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Wait for the next half-period result, bounded
	task automatic wait_valid();
		int k;
		k = 0;
		@(negedge mclk_in);
		while (valid !== 1'b1 && k < 4 * HP) begin
			@(negedge mclk_in);
			k++;
		end
		check("result_valid", 16'(valid), 16'h0001);
	endtask
	// Hang guard
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	// Main sequence
	initial begin
		int lows;
		repeat (10) @(negedge mclk_in);
		rst_n_in = 1'b1;
		foreach (rows[i]) begin
			mv = rows[i].mv;
			repeat (8) wait_valid();
			check("last_duty", 16'(last_duty), 16'(rows[i].duty));
			check("ch1_off", ch1, 16'(HP * rows[i].duty / 1000));
			check("ch2_off", ch2, 16'(HP * rows[i].duty / 1000));
			check("pair_avg", avg, 16'(HP * rows[i].duty / 1000));
		end
		// Short overcurrent burst stays under the debounce time
		mv = 12'h258;
		repeat (40) @(negedge mclk_in);
		mv = 12'h000;
		repeat (100) @(negedge mclk_in);
		check("flag_burst", 16'(flag_n), 16'h0001);
		// Sustained overcurrent is not latched after 60 clocks and is latched by 120 clocks
		mv = 12'h258;
		repeat (60) @(negedge mclk_in);
		check("flag_early", 16'(flag_n), 16'h0001);
		repeat (60) @(negedge mclk_in);
		check("flag_late", 16'(flag_n), 16'h0000);
		check("fault_seen", 16'(fault_n), 16'h0000);
		lows = 0;
		repeat (2 * HP) begin
			@(negedge mclk_in);
			lows += int'(!link.duty_line);
		end
		check("duty_lows", 16'(lows), 16'h0000);
		// Clear while overcurrent persists: flag releases then relatches
		clr = 1'b1;
		repeat (3) @(negedge mclk_in);
		clr = 1'b0;
		lows = 0;
		repeat (3 * HP) begin
			@(negedge mclk_in);
			lows += int'(flag_n);
		end
		check("flag_released", 16'(lows > 0), 16'h0001);
		check("flag_relatch", 16'(flag_n), 16'h0000);
		// Clear with input back to zero, duty stream resumes
		mv = 12'h000;
		clr = 1'b1;
		repeat (3) @(negedge mclk_in);
		clr = 1'b0;
		repeat (3 * HP) @(negedge mclk_in);
		check("flag_cleared", 16'(flag_n), 16'h0001);
		repeat (4) wait_valid();
		check("duty_resumed", 16'(last_duty), 16'h00c8);
		// Strapped flag clears itself and refires
		auto = 1'b1;
		mv = 12'h258;
		lows = 0;
		repeat (8 * HP) begin
			@(negedge mclk_in);
			lows += int'(!flag_n);
		end
		check("auto_toggle", 16'(lows > 0 && lows < 8 * HP), 16'h0001);
		// Mid-run reset returns everything to idle
		rst_n_in = 1'b0;
		repeat (10) @(negedge mclk_in);
		check("rst_flag", 16'(flag_n), 16'h0001);
		check("rst_timebase", 16'(link.aligned_timebase), 16'h0000);
		check("rst_duty_line", 16'(link.duty_line), 16'h0001);
		tally_and_finish();
	end
endmodule

//--- tb/phase_readout_chk.sv
// Purpose: Timing checks on the sensor to controller link
// Assumes: One clock, synchronous active-low reset
// Notes: Sees only the link signals
`timescale 1ns/10ps
module phase_readout_chk #(
	parameter int HALF_PERIOD = 1250
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic aligned_timebase,
	input wire logic duty_pull_oe,
	input wire logic duty_clear_oe,
	input wire logic fault_pull_oe,
	input wire logic duty_line
);
	logic tb_d_reg;
	logic [15:0] since_edge_reg;
	logic [15:0] pull_len_reg;
	logic [15:0] low_run_reg;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	// Run lengths: since timebase edge, of sensor pull, of low duty line
	always_ff @(posedge mclk_in) begin
		tb_d_reg <= aligned_timebase;
		if (!rst_n_in) begin
			since_edge_reg <= 16'h0000;
			pull_len_reg <= 16'h0000;
			low_run_reg <= 16'h0000;
		end else begin
			since_edge_reg <= (aligned_timebase != tb_d_reg) ? 16'h0000 : since_edge_reg + 16'h0001;
			pull_len_reg <= duty_pull_oe ? pull_len_reg + 16'h0001 : 16'h0000;
			low_run_reg <= duty_line ? 16'h0000 : low_run_reg + 16'h0001;
		end
	end
	// Controller clear pulse is 17 cycles long
	sequence s_clear_burst;
		duty_clear_oe[*8] ##1 duty_clear_oe[*8] ##1 duty_clear_oe ##1 !duty_clear_oe;
	endsequence
	a_clear_pulse_len: assert property ($rose(duty_clear_oe) |-> s_clear_burst)
		else $error("clear pulse length wrong");
	a_fault_no_pull: assert property (fault_pull_oe[*2] |-> !duty_pull_oe)
		else $error("duty pulled during fault");
	a_pull_after_edge: assert property ($rose(duty_pull_oe) |->
		since_edge_reg >= 16'h0001 && since_edge_reg <= 16'h0005)
		else $error("duty pull not at timebase edge");
	a_pull_len_bound: assert property (pull_len_reg < HALF_PERIOD)
		else $error("duty pull too long");
	a_half_period: assert property (since_edge_reg <= HALF_PERIOD)
		else $error("timebase half too long");
	a_fault_holds: assert property ((fault_pull_oe && duty_line)[*4] |=> fault_pull_oe)
		else $error("fault dropped without clear");
	a_clear_needs_low: assert property ($fell(fault_pull_oe) |-> $past(low_run_reg) >= 16'h000a)
		else $error("fault cleared without low pulse");
	a_reset_state: assert property ($rose(rst_n_in) |->
		!aligned_timebase && !duty_pull_oe && !fault_pull_oe)
		else $error("link not idle after reset");
endmodule
